/* ugc_pkg.sv */
// Shared constants for the USB global control register bank and its controller
package ugc_pkg;

    // ==========================================
    // Device register offsets
    localparam logic [15:0] OFS_CTRL_STAT = 16'h7FD6;
    localparam logic [15:0] OFS_TOGGLE = 16'h7FD7;
    localparam logic [15:0] OFS_FRAME_LO = 16'h7FD8;
    localparam logic [15:0] OFS_FRAME_HI = 16'h7FD9;
    localparam logic [15:0] OFS_FUNC_ADDR = 16'h7FDB;
    localparam logic [15:0] OFS_PAIRING = 16'h7FDD;
    localparam logic [15:0] OFS_IN_VALID = 16'h7FDE;

    // ==========================================
    // Field positions
    localparam int CS_WAKE = 7;
    localparam int CS_DETACH = 3;
    localparam int CS_DETACH_OE = 2;
    localparam int CS_REQ_SEL = 1;
    localparam int CS_RESUME = 0;
    localparam int TG_VALUE = 7;
    localparam int TG_SET = 6;
    localparam int TG_CLR = 5;
    localparam int TG_DIR = 4;
    localparam int TG_EP_LSB = 0;
    localparam int TG_EP_W = 3;
    localparam int PR_ISO_ZLP = 7;
    localparam int PR_SPARE = 6;
    localparam int PR_OUT_LSB = 3;
    localparam int PR_IN_LSB = 0;
    localparam int PAIR_N = 3;

    // ==========================================
    // Widths and reset values
    localparam int FRAME_W = 11;
    localparam int ADDR_W = 7;
    localparam logic [7:0] CS_RESET = 8'h04;
    localparam logic [7:0] PAIR_RESET = 8'h00;
    localparam logic [7:0] IN_VALID_RESET = 8'h57;
    localparam logic [3:0] ISO_EP_FIRST = 4'h8;
    localparam logic [1:0] PAIR_FULL = 2'h2;

    // ==========================================
    // Controller APB map
    localparam logic [11:0] APB_CMD = 12'h000;
    localparam logic [11:0] APB_STAT = 12'h004;
    localparam int CMD_WDATA_LSB = 16;
    localparam int CMD_WRITE = 24;
    localparam int CMD_RESUME = 25;
    localparam int ST_BUSY = 8;
    localparam int ST_REFUSED = 9;

    // ==========================================
    // Timing
    localparam int CLK_MHZ = 100;
    localparam int RESUME_MIN_MS = 10;
    localparam int RESUME_MAX_MS = 15;
    localparam int RESUME_HOLD_CYC = RESUME_MIN_MS * 1000 * CLK_MHZ;

endpackage

/* ugc_reg_if.sv */
// Register port between the register bank and its controller
`timescale 1ns/10ps
interface ugc_reg_if (
    input wire logic pclk,
    input wire logic presetn
);
    logic [15:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
    logic [7:0] rdata;

    modport dev (
        input pclk,
        input presetn,
        input addr,
        input wdata,
        input wr,
        input rd,
        output rdata
    );

    modport ctl (
        input pclk,
        input presetn,
        output addr,
        output wdata,
        output wr,
        output rd,
        input rdata
    );
endinterface

/* ugc_fall_detect.sv */
// Two-stage synchroniser with falling-edge pulse
`timescale 1ns/10ps
module ugc_fall_detect (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Pin and event
    input wire logic pin_n,
    output logic fall
);
    logic meta_r;
    logic sync_r;
    logic last_r;

    // ==========================================
    // Synchroniser and edge
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            meta_r <= 1'b1;
            sync_r <= 1'b1;
            last_r <= 1'b1;
        end
        else
        begin
            meta_r <= pin_n;
            sync_r <= meta_r;
            last_r <= sync_r;
        end
    end

    assign fall = last_r & ~sync_r;
endmodule

/* ugc_device.sv */
// Global USB control and status register bank of the device core
`timescale 1ns/10ps
// Notes on behaviour
// RULE1: wake pin fall sets flag; write-one clears
// RULE2: detach pin driven to inverse control bit
// RULE3: output enable zero floats detach pin
// RULE4: select bit picks core or processor requests
// RULE5: boot done or external memory sets select
// RULE6: resume bit drives K; firmware holds 10-15ms
// RULE7: toggle value reads selected endpoint toggle
// RULE8: set bit forces selected toggle DATA1
// RULE9: clear bit forces selected toggle DATA0
// RULE10: direction bit plus three-bit endpoint select
// RULE11: every SOF latches eleven-bit frame number
// RULE12: missing SOF increments stored frame count
// RULE13: capture host address; answer only it
// RULE14: re-enumeration resets address to zero
// RULE15: empty iso IN: silence or zero-length
// RULE16: OUT pairing bits double-buffer bulk OUT
// RULE17: IN pairing bits double-buffer bulk IN
// RULE18: paired firmware uses even endpoint only
// RULE19: eight IN valid bits, reset 0x57
// RULE20: invalid endpoint gets no response
// RULE21: first paired IN load leaves busy low
// RULE22: wake pin synchronised before edge detect
module ugc_device (
    // Register port
    ugc_reg_if.dev bus,
    // Pins
    input wire logic wake_pin_n,
    output logic detach_pin_o,
    output logic detach_pin_oe,
    output logic resume_k_drive,
    // Straps and boot
    input wire logic external_memory_select,
    input wire logic eeprom_present,
    input wire logic boot_load_done,
    // Frame events
    input wire logic sof_seen,
    input wire logic [ugc_pkg::FRAME_W-1:0] sof_frame,
    input wire logic sof_lost,
    // Address assignment
    input wire logic set_addr_stb,
    input wire logic [ugc_pkg::ADDR_W-1:0] set_addr_val,
    // Toggle flips from packet engine
    input wire logic tgl_flip_stb,
    input wire logic tgl_flip_in,
    input wire logic [ugc_pkg::TG_EP_W-1:0] tgl_flip_ep,
    // Token decision
    input wire logic tok_stb,
    input wire logic [ugc_pkg::ADDR_W-1:0] tok_addr,
    input wire logic tok_in,
    input wire logic [3:0] tok_ep,
    input wire logic tok_fifo_empty,
    output logic tok_done,
    output logic tok_respond,
    output logic tok_zlp,
    // Control outputs
    output logic request_handler_select,
    output logic [ugc_pkg::PAIR_N-1:0] out_pair_enable,
    output logic [ugc_pkg::PAIR_N-1:0] in_pair_enable,
    // Paired IN buffers
    input wire logic [ugc_pkg::PAIR_N-1:0] in_bc_wr_even,
    input wire logic [ugc_pkg::PAIR_N-1:0] in_pkt_sent_even,
    output logic [ugc_pkg::PAIR_N-1:0] in_pair_busy
);
    logic wake_fall;
    logic wake_r;
    logic wake_nxt;
    logic detach_r;
    logic detach_nxt;
    logic req_sel_r;
    logic req_sel_nxt;
    logic strap_seen_r;
    logic [15:0] toggle_r;
    logic [15:0] toggle_nxt;
    logic tgl_dir_r;
    logic [ugc_pkg::TG_EP_W-1:0] tgl_ep_r;
    logic [ugc_pkg::FRAME_W-1:0] frame_r;
    logic [ugc_pkg::FRAME_W-1:0] frame_nxt;
    logic [ugc_pkg::ADDR_W-1:0] faddr_r;
    logic [ugc_pkg::ADDR_W-1:0] faddr_nxt;
    logic [7:0] pair_r;
    logic [7:0] in_valid_r;
    logic [7:0] rdata_r;

    // ==========================================
    // Address decode
    wire cs_wr = bus.wr && (bus.addr == ugc_pkg::OFS_CTRL_STAT);
    wire tg_wr = bus.wr && (bus.addr == ugc_pkg::OFS_TOGGLE);
    wire pr_wr = bus.wr && (bus.addr == ugc_pkg::OFS_PAIRING);
    wire iv_wr = bus.wr && (bus.addr == ugc_pkg::OFS_IN_VALID);
    wire [3:0] tg_wsel = {bus.wdata[ugc_pkg::TG_DIR],
        bus.wdata[ugc_pkg::TG_EP_LSB +: ugc_pkg::TG_EP_W]};
    wire [3:0] tg_rsel = {tgl_dir_r, tgl_ep_r};
    wire [3:0] flip_sel = {tgl_flip_in, tgl_flip_ep};

    // ==========================================
    // Wake flag
    // RULE22: synchronised edge
    ugc_fall_detect u_wake (
        .pclk(bus.pclk),
        .presetn(bus.presetn),
        .pin_n(wake_pin_n),
        .fall(wake_fall)
    );

    // RULE1: set beats clear
    assign wake_nxt = wake_fall | (wake_r & ~(cs_wr & bus.wdata[ugc_pkg::CS_WAKE]));

    // ==========================================
    // Control bits
    // RULE2: pin is inverse bit
    assign detach_nxt = cs_wr ? bus.wdata[ugc_pkg::CS_DETACH] : detach_r;
    // RULE5: hardware sets select
    wire req_sel_set = boot_load_done
        | (strap_seen_r & external_memory_select & ~eeprom_present);
    // RULE4: request routing select
    assign req_sel_nxt = req_sel_set | (cs_wr ? bus.wdata[ugc_pkg::CS_REQ_SEL] : req_sel_r);
    // RULE14: re-enumeration clears address
    wire request_handler_select_start = req_sel_nxt & ~req_sel_r;
    // RULE13: captured host address
    assign faddr_nxt = request_handler_select_start ? '0 : (set_addr_stb ? set_addr_val : faddr_r);

    // ==========================================
    // Frame count
    // RULE11: latch on SOF
    // RULE12: synthesised SOF counts
    assign frame_nxt = sof_seen ? sof_frame
        : (sof_lost ? ugc_pkg::FRAME_W'(frame_r + 1'b1) : frame_r);

    // ==========================================
    // Data toggles
    genvar g;
    generate
        for (g = 0; g < 16; g++)
        begin : g_tgl
            // RULE8: force DATA1
            // RULE9: force DATA0
            assign toggle_nxt[g] =
                (tg_wr && tg_wsel == 4'(g) && bus.wdata[ugc_pkg::TG_SET]) ? 1'b1 :
                (tg_wr && tg_wsel == 4'(g) && bus.wdata[ugc_pkg::TG_CLR]) ? 1'b0 :
                (tgl_flip_stb && flip_sel == 4'(g)) ? ~toggle_r[g] : toggle_r[g];
        end
    endgenerate

    // ==========================================
    // Paired IN buffers
    generate
        for (g = 0; g < ugc_pkg::PAIR_N; g++)
        begin : g_pair
            logic [1:0] full_r;
            wire [1:0] full_nxt = 2'(full_r + {1'b0, in_bc_wr_even[g]}
                - {1'b0, in_pkt_sent_even[g] & (full_r != 2'h0)});
            always_ff @(posedge bus.pclk or negedge bus.presetn)
            begin
                if (!bus.presetn)
                begin
                    full_r <= 2'h0;
                    in_pair_busy[g] <= 1'b0;
                end
                else
                begin
                    full_r <= full_nxt;
                    // RULE17: two buffers when paired
                    // RULE21: one full buffer is not busy
                    in_pair_busy[g] <= pair_r[ugc_pkg::PR_IN_LSB + g]
                        ? (full_nxt == ugc_pkg::PAIR_FULL) : (full_nxt != 2'h0);
                end
            end
        end
    endgenerate

    // ==========================================
    // Token decision
    wire tok_hit = (tok_addr == faddr_r);
    wire tok_iso = (tok_ep >= ugc_pkg::ISO_EP_FIRST);
    // RULE20: invalid IN endpoint silent
    wire tok_ep_ok = (tok_in && !tok_iso) ? in_valid_r[tok_ep[2:0]] : 1'b1;
    wire tok_iso_empty = tok_in & tok_iso & tok_fifo_empty;
    wire zlp_on = pair_r[ugc_pkg::PR_ISO_ZLP];

    // ==========================================
    // Read mux
    wire [7:0] cs_val = {wake_r, 3'h0, detach_r, detach_pin_oe, req_sel_r, resume_k_drive};
    // RULE7: selected toggle value
    wire [7:0] tg_val = {toggle_r[tg_rsel], 2'h0, tgl_dir_r, 1'b0, tgl_ep_r};
    wire [7:0] rd_val =
        (bus.addr == ugc_pkg::OFS_CTRL_STAT) ? cs_val :
        (bus.addr == ugc_pkg::OFS_TOGGLE) ? tg_val :
        (bus.addr == ugc_pkg::OFS_FRAME_LO) ? frame_r[7:0] :
        (bus.addr == ugc_pkg::OFS_FRAME_HI) ? {5'h00, frame_r[10:8]} :
        (bus.addr == ugc_pkg::OFS_FUNC_ADDR) ? {1'b0, faddr_r} :
        (bus.addr == ugc_pkg::OFS_PAIRING) ? pair_r :
        (bus.addr == ugc_pkg::OFS_IN_VALID) ? in_valid_r : 8'h00;

    // ==========================================
    // Register state
    always_ff @(posedge bus.pclk or negedge bus.presetn)
    begin
        if (!bus.presetn)
        begin
            wake_r <= ugc_pkg::CS_RESET[ugc_pkg::CS_WAKE];
            detach_r <= ugc_pkg::CS_RESET[ugc_pkg::CS_DETACH];
            detach_pin_o <= ~ugc_pkg::CS_RESET[ugc_pkg::CS_DETACH];
            detach_pin_oe <= ugc_pkg::CS_RESET[ugc_pkg::CS_DETACH_OE];
            req_sel_r <= ugc_pkg::CS_RESET[ugc_pkg::CS_REQ_SEL];
            resume_k_drive <= ugc_pkg::CS_RESET[ugc_pkg::CS_RESUME];
            strap_seen_r <= 1'b0;
            toggle_r <= 16'h0000;
            tgl_dir_r <= 1'b0;
            tgl_ep_r <= '0;
            frame_r <= '0;
            faddr_r <= '0;
            pair_r <= ugc_pkg::PAIR_RESET;
            in_valid_r <= ugc_pkg::IN_VALID_RESET;
            rdata_r <= 8'h00;
        end
        else
        begin
            wake_r <= wake_nxt;
            detach_r <= detach_nxt;
            // RULE2: inverse of control bit
            detach_pin_o <= ~detach_nxt;
            // RULE3: enable floats or drives
            if (cs_wr)
                detach_pin_oe <= bus.wdata[ugc_pkg::CS_DETACH_OE];
            // RULE6: K state while set
            if (cs_wr)
                resume_k_drive <= bus.wdata[ugc_pkg::CS_RESUME];
            req_sel_r <= req_sel_nxt;
            strap_seen_r <= 1'b1;
            toggle_r <= toggle_nxt;
            // RULE10: direction and endpoint
            if (tg_wr)
            begin
                tgl_dir_r <= bus.wdata[ugc_pkg::TG_DIR];
                tgl_ep_r <= bus.wdata[ugc_pkg::TG_EP_LSB +: ugc_pkg::TG_EP_W];
            end
            frame_r <= frame_nxt;
            faddr_r <= faddr_nxt;
            // RULE16: pairing bits stored
            if (pr_wr)
                pair_r <= bus.wdata;
            // RULE19: IN valid bits
            if (iv_wr)
                in_valid_r <= bus.wdata;
            if (bus.rd)
                rdata_r <= rd_val;
        end
    end

    // ==========================================
    // Token answer
    always_ff @(posedge bus.pclk or negedge bus.presetn)
    begin
        if (!bus.presetn)
        begin
            tok_done <= 1'b0;
            tok_respond <= 1'b0;
            tok_zlp <= 1'b0;
        end
        else
        begin
            tok_done <= tok_stb;
            // RULE13: only own address
            // RULE15: empty iso reply choice
            tok_respond <= tok_stb & tok_hit & tok_ep_ok & ~(tok_iso_empty & ~zlp_on);
            tok_zlp <= tok_stb & tok_hit & tok_iso_empty & zlp_on;
        end
    end

    assign bus.rdata = rdata_r;
    assign request_handler_select = req_sel_r;
    assign out_pair_enable = pair_r[ugc_pkg::PR_OUT_LSB +: ugc_pkg::PAIR_N];
    assign in_pair_enable = pair_r[ugc_pkg::PR_IN_LSB +: ugc_pkg::PAIR_N];
endmodule

/* ugc_ctl.sv */
// APB-driven controller that reaches the register bank over its register port
`timescale 1ns/10ps
module ugc_ctl #(
    parameter int HOLD_CYCLES = ugc_pkg::RESUME_HOLD_CYC
) (
    // Register port
    ugc_reg_if.ctl bus,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    // USB state
    input wire logic usb_suspended
);
    typedef enum logic [4:0] {
        UGC_IDLE = 5'b00001,
        UGC_READ = 5'b00010,
        UGC_CAPT = 5'b00100,
        UGC_HOLD = 5'b01000,
        UGC_CLRK = 5'b10000
    } ugc_state_t;

    ugc_state_t state_r;
    ugc_state_t state_nxt;
    logic [15:0] addr_r;
    logic [15:0] addr_nxt;
    logic [7:0] wdata_r;
    logic [7:0] wdata_nxt;
    logic wr_r;
    logic wr_nxt;
    logic rd_r;
    logic rd_nxt;
    logic resume_r;
    logic resume_nxt;
    logic refused_r;
    logic refused_nxt;
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;
    logic [31:0] cnt_r;
    logic [31:0] cnt_nxt;

    // ==========================================
    // APB decode
    wire apb_done = psel & penable & pready;
    wire cmd_go = apb_done & pwrite & (paddr == ugc_pkg::APB_CMD);
    wire busy = (state_r != UGC_IDLE) | wr_r | rd_r;
    wire [7:0] cmd_wdata = pwdata[ugc_pkg::CMD_WDATA_LSB +: 8];
    wire [31:0] stat_val = {22'h000000, refused_r, busy, rdata_r};
    wire [7:0] resume_mask = 8'(1 << ugc_pkg::CS_RESUME);
    // Never write back a one into the write-one-to-clear wake flag
    wire [7:0] wake_mask = 8'(1 << ugc_pkg::CS_WAKE);

    // ==========================================
    // Sequencer
    always_comb
    begin
        state_nxt = state_r;
        addr_nxt = addr_r;
        wdata_nxt = wdata_r;
        wr_nxt = 1'b0;
        rd_nxt = 1'b0;
        resume_nxt = resume_r;
        refused_nxt = refused_r;
        rdata_nxt = rdata_r;
        cnt_nxt = cnt_r;
        unique case (state_r)
            UGC_IDLE:
            begin
                if (cmd_go && !busy)
                begin
                    refused_nxt = 1'b0;
                    if (pwdata[ugc_pkg::CMD_RESUME])
                    begin
                        // RULE6: resume only in suspend
                        if (usb_suspended)
                        begin
                            addr_nxt = ugc_pkg::OFS_CTRL_STAT;
                            rd_nxt = 1'b1;
                            resume_nxt = 1'b1;
                            state_nxt = UGC_READ;
                        end
                        else
                        begin
                            refused_nxt = 1'b1;
                        end
                    end
                    else
                    begin
                        // RULE8: selection and set together
                        // RULE9: selection and clear together
                        addr_nxt = pwdata[15:0];
                        wdata_nxt = cmd_wdata;
                        wr_nxt = pwdata[ugc_pkg::CMD_WRITE];
                        rd_nxt = ~pwdata[ugc_pkg::CMD_WRITE];
                        state_nxt = pwdata[ugc_pkg::CMD_WRITE] ? UGC_IDLE : UGC_READ;
                    end
                end
            end
            UGC_READ:
            begin
                state_nxt = UGC_CAPT;
            end
            UGC_CAPT:
            begin
                rdata_nxt = bus.rdata;
                if (resume_r)
                begin
                    wdata_nxt = (bus.rdata & ~wake_mask) | resume_mask;
                    wr_nxt = 1'b1;
                    cnt_nxt = 32'h00000000;
                    state_nxt = UGC_HOLD;
                end
                else
                begin
                    state_nxt = UGC_IDLE;
                end
            end
            UGC_HOLD:
            begin
                // RULE6: hold K then release
                cnt_nxt = cnt_r + 32'h00000001;
                if (cnt_r == 32'(HOLD_CYCLES - 1))
                begin
                    wdata_nxt = wdata_r & ~resume_mask;
                    wr_nxt = 1'b1;
                    state_nxt = UGC_CLRK;
                end
            end
            UGC_CLRK:
            begin
                resume_nxt = 1'b0;
                state_nxt = UGC_IDLE;
            end
        endcase
    end

    // ==========================================
    // State registers
    always_ff @(posedge bus.pclk or negedge bus.presetn)
    begin
        if (!bus.presetn)
        begin
            state_r <= UGC_IDLE;
            addr_r <= 16'h0000;
            wdata_r <= 8'h00;
            wr_r <= 1'b0;
            rd_r <= 1'b0;
            resume_r <= 1'b0;
            refused_r <= 1'b0;
            rdata_r <= 8'h00;
            cnt_r <= 32'h00000000;
        end
        else
        begin
            state_r <= state_nxt;
            addr_r <= addr_nxt;
            wdata_r <= wdata_nxt;
            wr_r <= wr_nxt;
            rd_r <= rd_nxt;
            resume_r <= resume_nxt;
            refused_r <= refused_nxt;
            rdata_r <= rdata_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    // ==========================================
    // APB answer
    always_ff @(posedge bus.pclk or negedge bus.presetn)
    begin
        if (!bus.presetn)
        begin
            pready <= 1'b0;
            prdata <= 32'h00000000;
        end
        else
        begin
            pready <= psel & penable & ~pready;
            if (psel && penable && !pready)
                prdata <= (!pwrite && paddr == ugc_pkg::APB_STAT) ? stat_val : 32'h00000000;
        end
    end

    assign bus.addr = addr_r;
    assign bus.wdata = wdata_r;
    assign bus.wr = wr_r;
    assign bus.rd = rd_r;
endmodule

/* ugc_sva.sv */
// Concurrent checks on the register port and device pins
`timescale 1ns/10ps
module ugc_sva (
    // Clock, reset and register port
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [15:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    // Device pins and events
    input wire logic detach_pin_o,
    input wire logic detach_pin_oe,
    input wire logic resume_k_drive,
    input wire logic boot_load_done,
    input wire logic request_handler_select,
    input wire logic tok_stb,
    input wire logic tok_in,
    input wire logic tok_done,
    input wire logic tok_respond,
    input wire logic tok_zlp,
    input wire logic [2:0] out_pair_enable,
    input wire logic [2:0] in_pair_enable,
    input wire logic [2:0] in_bc_wr_even,
    input wire logic [2:0] in_pair_busy
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    wire cs_wr = wr && addr == ugc_pkg::OFS_CTRL_STAT;
    wire pr_wr = wr && addr == ugc_pkg::OFS_PAIRING;
    // ==========================================
    // Assertions
    property p_detach; cs_wr |=> detach_pin_o == !$past(wdata[3]); endproperty
    a_detach: assert property (p_detach) else $error("detach pin level wrong");
    property p_detach_oe; cs_wr |=> detach_pin_oe == $past(wdata[2]); endproperty
    a_detach_oe: assert property (p_detach_oe) else $error("detach enable wrong");
    property p_resume; cs_wr |=> resume_k_drive == $past(wdata[0]); endproperty
    a_resume: assert property (p_resume) else $error("resume drive wrong");
    property p_boot; boot_load_done |=> request_handler_select; endproperty
    a_boot: assert property (p_boot) else $error("boot done left select low");
    property p_pair; pr_wr |=> {out_pair_enable, in_pair_enable} == $past(wdata[5:0]); endproperty
    a_pair: assert property (p_pair) else $error("pairing outputs wrong");
    property p_tok; tok_done == $past(tok_stb); endproperty
    a_tok: assert property (p_tok) else $error("token answer timing wrong");
    property p_zlp; tok_zlp |-> tok_respond; endproperty
    a_zlp: assert property (p_zlp) else $error("zero length without reply");
    property p_zlp_out; tok_stb && !tok_in |=> !tok_zlp; endproperty
    a_zlp_out: assert property (p_zlp_out) else $error("zero length on OUT");
    property p_busy; $rose(in_pair_busy[0]) && in_pair_enable[0] |-> $past(in_bc_wr_even[0]);
    endproperty
    a_busy: assert property (p_busy) else $error("paired busy without load");
endmodule

/* usb_global_control_regs_bench.sv */
// Self-checking bench for the joined controller and register bank
`timescale 1ns/10ps
module usb_global_control_regs_bench;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, usb_suspended = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, s;
    logic pready, detach_pin_o, detach_pin_oe, resume_k_drive, tok_done, tok_respond, tok_zlp;
    logic wake_pin_n = 1'b1, external_memory_select = 1'b0, eeprom_present = 1'b1;
    logic tgl_flip_in = 1'b1, tok_stb = 1'b0, tok_in = 1'b0, tok_fifo_empty = 1'b1;
    logic request_handler_select;
    logic [10:0] sof_frame = 11'h5A3;
    logic [10:0] pl = 11'h000;
    logic [6:0] set_addr_val = 7'h2A, tok_addr = 7'h00;
    logic [2:0] tgl_flip_ep = 3'h4, out_pair_enable, in_pair_enable, in_pair_busy;
    logic [3:0] tok_ep = 4'h0;
    int num_errors = 0;
    int checked = 0;

    ugc_reg_if bus_if (.pclk(pclk), .presetn(presetn));
    ugc_device i_ugc_device (.bus(bus_if.dev), .sof_seen(pl[0]), .sof_lost(pl[1]),
        .set_addr_stb(pl[2]), .tgl_flip_stb(pl[3]), .boot_load_done(pl[4]),
        .in_bc_wr_even(pl[7:5]), .in_pkt_sent_even(pl[10:8]), .*);
    ugc_ctl #(.HOLD_CYCLES(20)) i_ugc_ctl (.bus(bus_if.ctl), .*);
    ugc_sva i_ugc_sva (.addr(bus_if.addr), .wdata(bus_if.wdata), .wr(bus_if.wr),
        .boot_load_done(pl[4]), .in_bc_wr_even(pl[7:5]), .*);

    initial
    begin
        forever #5 pclk = ~pclk;
    end
    // ==========================================
    // Shared tasks
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            num_errors++;
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task results;
        if (num_errors == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        while (pready !== 1'b1)
            @(posedge pclk);
        s = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task dev(input logic [1:0] op, input logic [15:0] ofs, input logic [7:0] d);
        apb(1'b1, ugc_pkg::APB_CMD, {6'h00, op, d, ofs});
        wait_idle;
    endtask
    task wait_idle;
        do
            apb(1'b0, ugc_pkg::APB_STAT, 32'h0);
        while (s[ugc_pkg::ST_BUSY] !== 1'b0);
    endtask
    task rd_chk(input logic [15:0] ofs, input logic [7:0] exp);
        dev(2'b00, ofs, 8'h00);
        chk(s[7:0], exp);
    endtask
    task pulse(input int b);
        @(posedge pclk);
        pl[b] <= 1'b1;
        @(posedge pclk);
        pl[b] <= 1'b0;
        @(posedge pclk);
    endtask
    task tok(input logic [6:0] a, input logic i, input logic [3:0] e, input logic [1:0] exp);
        @(posedge pclk);
        tok_stb <= 1'b1;
        tok_addr <= a;
        tok_in <= i;
        tok_ep <= e;
        @(posedge pclk);
        tok_stb <= 1'b0;
        @(negedge pclk);
        chk({tok_done, tok_respond, tok_zlp}, {1'b1, exp});
    endtask
    // ==========================================
    // Scenarios
    task t_regs;
        rd_chk(ugc_pkg::OFS_CTRL_STAT, 8'h04);
        rd_chk(ugc_pkg::OFS_IN_VALID, 8'h57);
        rd_chk(16'h7FDA, 8'h00);
        @(posedge pclk) wake_pin_n <= 1'b0;
        rd_chk(ugc_pkg::OFS_CTRL_STAT, 8'h84);
        dev(2'b01, ugc_pkg::OFS_CTRL_STAT, 8'h84);
        rd_chk(ugc_pkg::OFS_CTRL_STAT, 8'h04);
        dev(2'b01, ugc_pkg::OFS_CTRL_STAT, 8'h0C);
        chk({detach_pin_oe, detach_pin_o}, 2'b10);
        dev(2'b01, ugc_pkg::OFS_CTRL_STAT, 8'h00);
        chk({detach_pin_oe, detach_pin_o}, 2'b01);
    endtask
    task t_toggle;
        dev(2'b01, ugc_pkg::OFS_TOGGLE, 8'h54);
        rd_chk(ugc_pkg::OFS_TOGGLE, 8'h94);
        dev(2'b01, ugc_pkg::OFS_TOGGLE, 8'h04);
        rd_chk(ugc_pkg::OFS_TOGGLE, 8'h04);
        dev(2'b01, ugc_pkg::OFS_TOGGLE, 8'h34);
        rd_chk(ugc_pkg::OFS_TOGGLE, 8'h14);
        pulse(3);
        rd_chk(ugc_pkg::OFS_TOGGLE, 8'h94);
        pulse(0);
        rd_chk(ugc_pkg::OFS_FRAME_LO, 8'hA3);
        rd_chk(ugc_pkg::OFS_FRAME_HI, 8'h05);
        pulse(1);
        rd_chk(ugc_pkg::OFS_FRAME_LO, 8'hA4);
    endtask
    task t_tokens;
        pulse(2);
        rd_chk(ugc_pkg::OFS_FUNC_ADDR, 8'h2A);
        tok(7'h2A, 1'b1, 4'h1, 2'b10);
        tok(7'h2B, 1'b1, 4'h1, 2'b00);
        tok(7'h2A, 1'b0, 4'h3, 2'b10);
        dev(2'b01, ugc_pkg::OFS_IN_VALID, 8'h55);
        tok(7'h2A, 1'b1, 4'h1, 2'b00);
        tok(7'h2A, 1'b1, 4'h0, 2'b10);
        tok(7'h2A, 1'b1, 4'h9, 2'b00);
        dev(2'b01, ugc_pkg::OFS_PAIRING, 8'hBF);
        tok(7'h2A, 1'b1, 4'h9, 2'b11);
        rd_chk(ugc_pkg::OFS_PAIRING, 8'hBF);
        pulse(5);
        chk(in_pair_busy[0], 1'b0);
        pulse(5);
        chk(in_pair_busy[0], 1'b1);
        pulse(8);
        chk(in_pair_busy[0], 1'b0);
    endtask
    task t_select;
        pulse(4);
        chk(request_handler_select, 1'b1);
        rd_chk(ugc_pkg::OFS_FUNC_ADDR, 8'h00);
        dev(2'b01, ugc_pkg::OFS_CTRL_STAT, 8'h04);
        chk(request_handler_select, 1'b0);
        @(posedge pclk) external_memory_select <= 1'b1;
        eeprom_present <= 1'b0;
        repeat (3) @(posedge pclk);
        chk(request_handler_select, 1'b1);
        @(posedge pclk) usb_suspended <= 1'b1;
        apb(1'b1, ugc_pkg::APB_CMD, 32'h0200_0000);
        repeat (10) @(posedge pclk);
        chk(resume_k_drive, 1'b1);
        wait_idle;
        chk(resume_k_drive, 1'b0);
        rd_chk(ugc_pkg::OFS_CTRL_STAT, 8'h06);
        @(posedge pclk) usb_suspended <= 1'b0;
        dev(2'b10, ugc_pkg::OFS_CTRL_STAT, 8'h00);
        chk({resume_k_drive, s[ugc_pkg::ST_REFUSED]}, 2'b01);
    endtask

    initial
    begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        t_regs;
        t_toggle;
        t_tokens;
        t_select;
        results;
    end
    initial
    begin
        #100us;
        num_errors++;
        results;
    end
endmodule
